// File: hw/acs_aux_control.sv
// Shadowed auxiliary control location with its shadow-000 control register.
`timescale 1ns/1ps
`default_nettype none

module acs_aux_control (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Management access
  input wire acs_pkg::acs_req_type req,
  output logic [15:0] rdata,
  output logic rvalid,
  // Strap pin, deliberately kept out of the register
  input wire logic [1:0] edge_rate_strap_pin,
  // Datapath controls
  output acs_pkg::acs_ctrl_type ctrl
);

  // Every check below lives in the core clock domain.
  default clocking acs_cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic hit(input acs_pkg::acs_req_type r);
    hit = (r.devad == acs_pkg::ACS_DEVAD) &&
          (r.addr == acs_pkg::ACS_REG_ADDR);
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Shadows other than 000 and 111 are held as plain storage so a
  // read-modify-write by the host round-trips; they steer nothing here.
  logic [15:0] aux_reg, aux_next;
  logic [15:0] misc_reg, misc_next;
  logic [15:0] oth_reg [1:6];
  logic [15:0] oth_next [1:6];
  logic [2:0] rsel_reg, rsel_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  acs_pkg::acs_ctrl_type dec;
  acs_pkg::acs_ctrl_type rst_ctrl;
  logic [2:0] wsel;
  logic [15:0] wdat;

  assign wsel = req.wdata[2:0];
  assign wdat = req.wdata & acs_pkg::ACS_DATA_MASK;

  always_comb begin
    aux_next = aux_reg;
    misc_next = misc_reg;
    rsel_next = rsel_reg;
    for (int i = 1; i <= 6; i++) begin
      oth_next[i] = oth_reg[i];
    end
    if (req.wr && hit(req)) begin
      unique case (wsel)
        acs_pkg::ACS_SHADOW_AUX: begin
          aux_next = wdat;
        end
        acs_pkg::ACS_SHADOW_MISC: begin
          // Bit 15 clear means only the read select is updated.
          if (req.wdata[acs_pkg::ACS_MISC_WEN_BIT]) begin
            misc_next = wdat;
          end else begin
            rsel_next = req.wdata[acs_pkg::ACS_RDSEL_LSB +: 3];
          end
        end
        default: begin
          oth_next[wsel] = wdat;
        end
      endcase
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // The strap input never enters this mux, so the edge-rate fields read
  // back exactly what was written.
  always_comb begin
    rvalid_next = req.rd && hit(req);
    rdata_next = rdata_reg;
    if (req.rd && hit(req)) begin
      unique case (rsel_reg)
        acs_pkg::ACS_SHADOW_AUX: rdata_next = aux_reg;
        acs_pkg::ACS_SHADOW_MISC: rdata_next = misc_reg | 16'(rsel_reg);
        default: rdata_next = oth_reg[rsel_reg];
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      aux_reg <= acs_pkg::ACS_AUX_RESET;
      misc_reg <= acs_pkg::ACS_MISC_RESET;
      rsel_reg <= acs_pkg::ACS_SHADOW_AUX;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
      for (int i = 1; i <= 6; i++) begin
        oth_reg[i] <= 16'h0000;
      end
    end else begin
      aux_reg <= aux_next;
      misc_reg <= misc_next;
      rsel_reg <= rsel_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      for (int i = 1; i <= 6; i++) begin
        oth_reg[i] <= oth_next[i];
      end
    end
  end

  acs_field_decode u_dec (
    .word(aux_reg),
    .ctrl(dec)
  );

  // The reset controls come from the same decoder, so they cannot drift
  // away from the stored reset word.
  acs_field_decode u_rst_dec (
    .word(acs_pkg::ACS_AUX_RESET),
    .ctrl(rst_ctrl)
  );

  // Controls are registered once more so the outputs are flop driven.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl <= rst_ctrl;
    end else begin
      ctrl <= dec;
    end
  end

  assign rdata = rdata_reg;
  assign rvalid = rvalid_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // None of these means anything while reset is held, so the default
  // disable above covers every one of them.
  a_aux_write_lands: assert property (
    req.wr && hit(req) && wsel == 3'h0 |=> aux_reg == $past(wdat))
    else $error("Shadow 000 write not stored.");
  a_other_store: assert property (
    req.wr && hit(req) && wsel == 3'h2 |=> oth_reg[2] == $past(wdat))
    else $error("Shadow 010 write not stored.");
  a_loopback_follows: assert property (
    ##1 ctrl.ext_loopback == $past(aux_reg[15]))
    else $error("Loopback control does not follow bit 15.");
  a_extlen_follows: assert property (
    ##1 ctrl.ext_pkt_len == $past(aux_reg[14]))
    else $error("Packet length control does not follow bit 14.");
  a_gig_edge: assert property (
    ##1 ctrl.gig_edge == $past(aux_reg[13:12]))
    else $error("Gigabit edge rate mismatch.");
  a_fe_edge: assert property (
    ##1 ctrl.fe_edge == $past(aux_reg[5:4]))
    else $error("Fast edge rate mismatch.");
  a_txmode_prf: assert property (
    ##1 ctrl.tx_normal == $past(aux_reg[10]) &&
    ctrl.prf_disable == $past(aux_reg[7]))
    else $error("Transmit mode or filter control mismatch.");
  a_read_aux: assert property (
    req.rd && hit(req) && rsel_reg == 3'h0 |=> rvalid &&
    rdata == $past(aux_reg))
    else $error("Shadow 000 read-back wrong.");
  a_read_other: assert property (
    req.rd && hit(req) && rsel_reg == 3'h2 |=> rvalid &&
    rdata == $past(oth_reg[2]))
    else $error("Shadow 010 read-back wrong.");
  a_strap_ignored: assert property (
    $changed(edge_rate_strap_pin) && !req.wr |=> $stable(aux_reg))
    else $error("Strap pin change reached the register.");
  a_rsel_write: assert property (
    req.wr && hit(req) && wsel == 3'h7 && !req.wdata[15] |=>
    rsel_reg == $past(req.wdata[14:12]) && $stable(aux_reg))
    else $error("Read select update wrong.");
  a_misc_store: assert property (
    req.wr && hit(req) && wsel == 3'h7 && req.wdata[15] |=>
    misc_reg == $past(wdat) && $stable(rsel_reg))
    else $error("Shadow 111 write not stored.");
  a_read_misc: assert property (
    req.rd && hit(req) && rsel_reg == 3'h7 |=> rvalid &&
    rdata == ($past(misc_reg) | 16'h0007))
    else $error("Shadow 111 read-back wrong.");
  a_miss_ignored: assert property (
    req.rd && !hit(req) |=> !rvalid)
    else $error("Answer given to wrong address.");
  a_miss_write: assert property (
    req.wr && !hit(req) |=> $stable(aux_reg))
    else $error("Write to wrong address changed shadow 000.");
  a_rvalid_cause: assert property (
    rvalid |-> $past(req.rd) && $past(req.devad) == acs_pkg::ACS_DEVAD &&
    $past(req.addr) == acs_pkg::ACS_REG_ADDR)
    else $error("Answer without a matching read.");
  c_aux_write: cover property (
    req.wr && hit(req) && wsel == 3'h0);
  c_rsel_then_read: cover property (
    req.wr && hit(req) && wsel == 3'h7 ##[1:4] req.rd && hit(req));
  c_loopback_on: cover property (
    ctrl.ext_loopback);
  c_misc_store: cover property (
    req.wr && hit(req) && wsel == 3'h7 && req.wdata[15]);
  c_strap_change: cover property (
    $changed(edge_rate_strap_pin));

endmodule

`default_nettype wire

// File: hw/acs_pkg.sv
// Package with register map, field layout and reset values for the shadow bank.
`default_nettype none

package acs_pkg;

  // ****************************************************************
  // Addressing
  // ****************************************************************
  localparam logic [4:0] ACS_DEVAD = 5'h07;
  localparam logic [15:0] ACS_REG_ADDR = 16'hFFF8;
  localparam logic [2:0] ACS_SHADOW_AUX = 3'h0;
  localparam logic [2:0] ACS_SHADOW_MISC = 3'h7;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ACS_SEL_LSB = 0;
  localparam int ACS_RDSEL_LSB = 12;
  localparam int ACS_MISC_WEN_BIT = 15;
  localparam int ACS_LOOPBACK_BIT = 15;
  localparam int ACS_EXT_LEN_BIT = 14;
  localparam int ACS_GIG_ER_LSB = 12;
  localparam int ACS_TX_MODE_BIT = 10;
  localparam int ACS_PRF_DIS_BIT = 7;
  localparam int ACS_FE_ER_LSB = 4;

  // Upper 13 bits of every shadow are stored; the low 3 are the select.
  localparam logic [15:0] ACS_DATA_MASK = 16'hFFF8;
  // Reset: extended length and normal transmit mode set, rest clear.
  localparam logic [15:0] ACS_AUX_RESET = 16'h4400;
  localparam logic [15:0] ACS_MISC_RESET = 16'h0000;

  // Edge-rate codes: 4.0 ns, 5.0 ns, 3.0 ns, 0.0 ns.
  typedef enum logic [1:0] {
    ACS_ER_4NS = 2'b00,
    ACS_ER_5NS = 2'b01,
    ACS_ER_3NS = 2'b10,
    ACS_ER_0NS = 2'b11
  } acs_edge_type;

  // Management access request carried as one bundle.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] devad;
    logic [15:0] addr;
    logic [15:0] wdata;
  } acs_req_type;

  // Decoded control fields driven to the copper datapath.
  typedef struct packed {
    logic ext_loopback;
    logic ext_pkt_len;
    acs_edge_type gig_edge;
    logic tx_normal;
    logic prf_disable;
    acs_edge_type fe_edge;
  } acs_ctrl_type;

endpackage

`default_nettype wire

// File: hw/acs_field_decode.sv
// Decoder from the stored shadow-000 word to the datapath control bundle.
`timescale 1ns/1ps
`default_nettype none

module acs_field_decode (
  // Stored register word
  input wire logic [15:0] word,
  // Decoded controls
  output acs_pkg::acs_ctrl_type ctrl
);

  always_comb begin
    ctrl.ext_loopback = word[acs_pkg::ACS_LOOPBACK_BIT];
    ctrl.ext_pkt_len = word[acs_pkg::ACS_EXT_LEN_BIT];
    ctrl.gig_edge = acs_pkg::acs_edge_type'(
      word[acs_pkg::ACS_GIG_ER_LSB +: 2]);
    ctrl.tx_normal = word[acs_pkg::ACS_TX_MODE_BIT];
    ctrl.prf_disable = word[acs_pkg::ACS_PRF_DIS_BIT];
    ctrl.fe_edge = acs_pkg::acs_edge_type'(
      word[acs_pkg::ACS_FE_ER_LSB +: 2]);
  end

endmodule

`default_nettype wire

// File: testbench/acs_host.sv
// Management host model that issues accesses to the shadow location.
`timescale 1ns/1ps
`default_nettype none

module acs_host (
  // Clock
  input wire logic core_clk,
  // Device answer
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  // Request bundle
  output acs_pkg::acs_req_type req
);
  initial req = '0;

  // ****************************************************************
  // One access
  // ****************************************************************
  // Released address and data lines carry inverted values and both strobes drop, so stale data never looks valid.
  task automatic xfer(input logic w, input logic [4:0] dv,
                      input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q = 16'h0000;
    @(posedge core_clk);
    req <= '{wr: w, rd: !w, devad: dv, addr: a, wdata: d};
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b0, devad: ~dv, addr: ~a, wdata: ~d};
    for (n = 0; n < 4 && !w && !ok; n++) begin
      @(posedge core_clk);
      ok = rvalid;
      q = rdata;
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/aux_control_shadow_register_tb.sv
// Self-checking bench for the shadow-000 auxiliary control register.
`timescale 1ns/1ps
`default_nettype none

module aux_control_shadow_register_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] edge_rate_strap_pin = 2'h0;
  acs_pkg::acs_req_type req;
  logic [15:0] rdata;
  logic rvalid;
  acs_pkg::acs_ctrl_type ctrl;
  int num_errors = 0;
  int comparisons = 0;
  // Reserved bits are masked out wherever their value is undefined.
  localparam logic [15:0] DEF = 16'hF4B0;

  always #10 core_clk = ~core_clk;

  acs_aux_control i_acs_aux_control (.core_clk(core_clk), .resetn(resetn),
    .req(req), .rdata(rdata), .rvalid(rvalid),
    .edge_rate_strap_pin(edge_rate_strap_pin), .ctrl(ctrl));
  acs_host i_acs_host (.core_clk(core_clk), .rdata(rdata), .rvalid(rvalid),
    .req(req));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [15:0] d);
    logic [15:0] q;
    logic ok;
    i_acs_host.xfer(1'b1, acs_pkg::ACS_DEVAD, acs_pkg::ACS_REG_ADDR, d, q, ok);
  endtask

  task automatic rreg(input logic [2:0] sel, output logic [15:0] q);
    logic ok;
    wreg({1'b0, sel, 12'h007});
    i_acs_host.xfer(1'b0, acs_pkg::ACS_DEVAD, acs_pkg::ACS_REG_ADDR,
      16'h0000, q, ok);
    check({15'h0000, ok}, 16'h0001);
  endtask

  task automatic check_ctrl(input logic [15:0] w);
    check({8'h00, ctrl}, {8'h00, w[15:12], w[10], w[7], w[5:4]});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_values();
    logic [15:0] q;
    rreg(3'h0, q);
    check(q & DEF, 16'h4400);
    check_ctrl(16'h4400);
  endtask

  task automatic field_walk();
    logic [15:0] tbl [8] = '{16'h8000, 16'h4400, 16'h1020, 16'h2010,
      16'h3430, 16'h0080, 16'h0000, 16'hFFF8};
    logic [15:0] q;
    foreach (tbl[i]) begin
      edge_rate_strap_pin <= ~tbl[i][13:12];
      wreg(tbl[i]);
      rreg(3'h0, q);
      check(q & DEF, tbl[i] & DEF);
      check_ctrl(tbl[i]);
    end
  endtask

  task automatic refusals();
    logic [15:0] q;
    logic ok;
    wreg(16'hAB02);
    i_acs_host.xfer(1'b1, acs_pkg::ACS_DEVAD, 16'hFFF7, 16'h0000, q, ok);
    i_acs_host.xfer(1'b0, 5'h01, acs_pkg::ACS_REG_ADDR, 16'h0000, q, ok);
    check({15'h0000, ok}, 16'h0000);
    rreg(3'h2, q);
    check(q & 16'hFFF8, 16'hAB00);
    wreg(16'h8A07);
    rreg(3'h7, q);
    check(q, 16'h8A07);
    rreg(3'h0, q);
    check(q & DEF, 16'hF4B0);
    check_ctrl(16'hFFF8);
  endtask

  task automatic modify_write();
    logic [15:0] q;
    rreg(3'h0, q);
    wreg({q[15:3] ^ 13'h1000, 3'h0});
    rreg(3'h0, q);
    check(q & 16'hFFF8, 16'h7FF8);
    check_ctrl(16'h7FF8);
  endtask

  task automatic reset_again();
    logic [15:0] q;
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    check_ctrl(acs_pkg::ACS_AUX_RESET);
    resetn <= 1'b1;
    rreg(3'h0, q);
    check(q & DEF, acs_pkg::ACS_AUX_RESET);
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    reset_values();
    field_walk();
    refusals();
    modify_write();
    reset_again();
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
